// ### flash_ctl_defs.svh
`ifndef FLASH_CTL_DEFS_SVH
`define FLASH_CTL_DEFS_SVH
// command codes written to the device
`define CMD_READ_ARRAY   8'hff
`define CMD_READ_STATUS  8'h70
`define CMD_CLEAR_FLAGS  8'h50
`define CMD_ERASE_SETUP  8'h20
`define CMD_ERASE_GO     8'hd0
`define CMD_PROG_SETUP   8'h40
// device status bit positions
`define SB_READY         7
`define SB_ERASE_FAIL    5
`define SB_PROG_FAIL     4
`define SB_SUPPLY        3
// controller register offsets
`define REG_CTRL         4'h0
`define REG_ADDR         4'h1
`define REG_DATA         4'h2
`define REG_STATUS       4'h3
`define REG_IRQ_STAT     4'h4
`define REG_IRQ_MASK     4'h5
`define REG_RDATA        4'h6
// control opcodes
`define OP_READ          3'h1
`define OP_PROG          3'h2
`define OP_ERASE         3'h3
`define OP_CLEAR         3'h4
`define OP_ARRAY         3'h5
// irq bit positions
`define IRQ_DONE         0
`define IRQ_ERROR        1
`define IRQ_REFUSED      2
// bus timing in ns and derived cycles at 8 ns
`define CLK_NS           8
`define T_WP_NS          50
`define T_WPH_NS         30
`define T_ACC_NS         100
`define T_RS_NS          220
`define WP_CYC   ((`T_WP_NS + `CLK_NS - 1) / `CLK_NS)
`define WPH_CYC  ((`T_WPH_NS + `CLK_NS - 1) / `CLK_NS)
`define ACC_CYC  ((`T_ACC_NS + `CLK_NS - 1) / `CLK_NS)
`define RS_CYC   ((`T_RS_NS + `CLK_NS - 1) / `CLK_NS)
`endif

// ### flash_ctl_pkg.sv
package flash_ctl_pkg;
  typedef enum logic [2:0] {
    err_none     = 3'h0,
    err_supply   = 3'h1,
    err_program  = 3'h2,
    err_prog_sup = 3'h3,
    err_erase    = 3'h4,
    err_eras_sup = 3'h5,
    err_sequence = 3'h6,
    err_seq_sup  = 3'h7
  } err_code_e;
  typedef enum logic [3:0] {
    st_idle   = 4'h0,
    st_wlow   = 4'h1,
    st_whigh  = 4'h3,
    st_rlow   = 4'h2,
    st_rdone  = 4'h6,
    st_next   = 4'h7,
    st_recov  = 4'h5,
    st_poll   = 4'h4
  } bus_state_e;
  typedef logic [7:0] byte_t;
endpackage

// ### flash_dev_model.sv
`timescale 1ns/100ps
module flash_dev_model #(
  parameter int BUSY_CYC = 30
) (
  input  wire logic        clk,        // bench clock
  input  wire logic [16:0] fl_addr,    // address pins
  input  wire logic [7:0]  fl_dq_out,  // data from host
  input  wire logic        fl_dq_oe,   // host drives data
  input  wire logic        fl_ce_n,    // chip select
  input  wire logic        fl_oe_n,    // output enable
  input  wire logic        fl_we_n,    // write strobe
  input  wire logic        fl_rst_n,   // device reset
  input  wire logic        supply_ok,  // program supply present
  input  wire logic [1:0]  inj_fail,   // erase, program fail inject
  output logic      [7:0]  fl_dq_in    // data to host
);
  import flash_ctl_pkg::*;
  byte_t       sr;
  byte_t       last = 8'h00;
  logic        stat_mode;
  logic        prev_we;
  logic  [1:0] pend;
  int          busy;
  // released bus toggles so a stale byte never passes for data
  assign fl_dq_in = (fl_ce_n || fl_oe_n) ? ~last :
      (stat_mode || busy != 0) ? sr : fl_addr[7:0] ^ 8'h5a;
  always @(posedge clk) begin
    last <= fl_dq_in;
    prev_we <= fl_we_n;
    if (!fl_rst_n) begin
      sr <= 8'h80;
      stat_mode <= 1'b0;
      pend <= 2'd0;
      busy <= 0;
    end else if (busy != 0) begin
      busy <= busy - 1;
      if (busy == 1) begin
        sr[7] <= 1'b1;
        sr[5:4] <= sr[5:4] | inj_fail;
      end
    end else if (fl_we_n && !prev_we && !fl_ce_n && fl_dq_oe) begin
      pend <= 2'd0;
      if (pend != 2'd0) begin
        if (pend == 2'd2 && fl_dq_out != 8'hd0) begin
          sr[5] <= 1'b1;
          stat_mode <= 1'b0;
        end else if (!sr[3]) begin
          busy <= BUSY_CYC;
          sr[7] <= 1'b0;
          stat_mode <= 1'b1;
          sr[3] <= !supply_ok;
        end
      end else begin
        case (fl_dq_out)
          8'hff: stat_mode <= 1'b0;
          8'h70: stat_mode <= 1'b1;
          8'h50: sr[5:3] <= 3'h0;
          8'h40: pend <= 2'd1;
          8'h20: pend <= 2'd2;
          default: pend <= 2'd0;
        endcase
      end
    end
  end
endmodule

// ### flash_err_decode.sv
`timescale 1ns/100ps
`include "flash_ctl_defs.svh"
module flash_err_decode (
  input  wire logic                    clk,       // clock
  input  wire logic                    reset,     // async reset
  input  wire flash_ctl_pkg::byte_t    status,    // device status byte
  output flash_ctl_pkg::err_code_e     err_code,  // registered decode
  output logic                         inhibit    // supply flag seen
);
  import flash_ctl_pkg::*;
  err_code_e next_err_code;
  logic      next_inhibit;

  always_comb begin
    next_err_code = err_code_e'({status[`SB_ERASE_FAIL],
                                 status[`SB_PROG_FAIL],
                                 status[`SB_SUPPLY]});
    next_inhibit  = status[`SB_SUPPLY];
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      err_code <= err_none;
      inhibit  <= 1'b0;
    end else begin
      err_code <= next_err_code;
      inhibit  <= next_inhibit;
    end
  end
endmodule

// ### flash_host_ctl.sv
// The plain strobed port and the placing of the registers were decided locally.
`timescale 1ns/100ps
`include "flash_ctl_defs.svh"
// Operation
// - device stays in status mode after operation; host writes ffh to leave
// - host may program many bytes before checking; clear before retry
// - host may erase several blocks back to back
// - host holds reset or strobes high during power-up
// - bit seven is ready; host waits for ready before trusting flags
module flash_host_ctl (
  input  wire logic        clk,        // 125 mhz clock
  input  wire logic        reset,      // async reset, active high
  input  wire logic [3:0]  reg_addr,   // register address
  input  wire logic [31:0] reg_wdata,  // register write data
  input  wire logic        reg_wr,     // write strobe
  input  wire logic        reg_rd,     // read strobe
  output logic [31:0]      reg_rdata,  // read data, cycle after strobe
  output logic             irq,        // level interrupt
  output logic [16:0]      fl_addr,    // flash address
  output logic [7:0]       fl_dq_out,  // flash data out
  output logic             fl_dq_oe,   // flash data drive enable
  input  wire logic [7:0]  fl_dq_in,   // flash data in
  output logic             fl_ce_n,    // chip select, low active
  output logic             fl_oe_n,    // output enable, low active
  output logic             fl_we_n,    // write strobe, low active
  output logic             fl_rst_n    // device reset, low active
);
  import flash_ctl_pkg::*;
  ////////////////////////////////////////////////////////////////////////////
  // pin input sync: three flops, change accepted when second and third agree
  byte_t dq_s1, dq_s2, dq_s3, dq_q;
  byte_t next_dq_q;
  always_comb begin
    next_dq_q = (dq_s2 == dq_s3) ? dq_s3 : dq_q;
  end
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      dq_s1 <= 8'h00;
      dq_s2 <= 8'h00;
      dq_s3 <= 8'h00;
      dq_q  <= 8'h00;
    end else begin
      dq_s1 <= fl_dq_in;
      dq_s2 <= dq_s1;
      dq_s3 <= dq_s2;
      dq_q  <= next_dq_q;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  err_code_e err_code;
  logic      inhibit;
  byte_t     status_q;
  flash_err_decode u_decode (
    .clk      (clk),
    .reset    (reset),
    .status   (status_q),
    .err_code (err_code),
    .inhibit  (inhibit)
  );
  function automatic logic [7:0] cyc8(input int n);
    cyc8 = 8'(n);
  endfunction
  ////////////////////////////////////////////////////////////////////////////
  // sequencer state
  bus_state_e state, next_state;
  logic [7:0]  cnt, next_cnt;
  logic [2:0]  op, next_op;
  logic [1:0]  step, next_step;
  logic        busy, next_busy;
  logic        status_mode, next_status_mode;
  logic [16:0] addr_r, next_addr_r;
  byte_t       data_r, next_data_r;
  byte_t       rdata_r, next_rdata_r;
  byte_t       next_status_q;
  logic [2:0]  irq_stat, next_irq_stat;
  logic [2:0]  irq_mask, next_irq_mask;
  logic [16:0] next_fl_addr;
  byte_t       next_fl_dq_out;
  logic        next_fl_dq_oe, next_fl_ce_n, next_fl_oe_n, next_fl_we_n;
  logic        next_fl_rst_n;
  logic [31:0] next_reg_rdata;
  logic        next_irq;
  logic [2:0]  ev;
  logic        start;
  logic [2:0]  req_op;
  byte_t       cmd;
  always_comb begin
    next_state       = state;
    next_cnt         = (cnt != 8'h00) ? cnt - 8'h01 : 8'h00;
    next_op          = op;
    next_step        = step;
    next_busy        = busy;
    next_status_mode = status_mode;
    next_addr_r      = addr_r;
    next_data_r      = data_r;
    next_rdata_r     = rdata_r;
    next_status_q    = status_q;
    next_irq_mask    = irq_mask;
    next_fl_addr     = fl_addr;
    next_fl_dq_out   = fl_dq_out;
    next_fl_dq_oe    = fl_dq_oe;
    next_fl_ce_n     = fl_ce_n;
    next_fl_oe_n     = fl_oe_n;
    next_fl_we_n     = fl_we_n;
    next_fl_rst_n    = 1'b1;
    next_reg_rdata   = 32'h0;
    ev               = 3'h0;
    start            = 1'b0;
    req_op           = reg_wdata[2:0];
    cmd              = `CMD_READ_ARRAY;
    // bus writes to controller registers
    if (reg_wr) begin
      case (reg_addr)
        `REG_CTRL: begin
          if (!busy) begin
            // refuse program or erase while supply flag stands
            if ((req_op == `OP_PROG || req_op == `OP_ERASE) && inhibit) begin
              ev[`IRQ_REFUSED] = 1'b1;
            end else if (req_op >= `OP_READ && req_op <= `OP_ARRAY) begin
              start = 1'b1;
            end
          end else begin
            ev[`IRQ_REFUSED] = 1'b1;
          end
        end
        `REG_ADDR:     next_addr_r   = reg_wdata[16:0];
        `REG_DATA:     next_data_r   = reg_wdata[7:0];
        `REG_IRQ_MASK: next_irq_mask = reg_wdata[2:0];
        default: ;
      endcase
    end

    if (start) begin
      next_op   = req_op;
      next_step = 2'h0;
      next_busy = 1'b1;
      next_state = st_next;
    end
    // command byte for the current step
    case (op)
      `OP_PROG:  cmd = (step == 2'h0) ? `CMD_PROG_SETUP : data_r;
      `OP_ERASE: cmd = (step == 2'h0) ? `CMD_ERASE_SETUP : `CMD_ERASE_GO;
      `OP_CLEAR: cmd = `CMD_CLEAR_FLAGS;
      `OP_ARRAY: cmd = `CMD_READ_ARRAY;
      default:   cmd = `CMD_READ_ARRAY;
    endcase
    case (state)
      st_idle: begin
        // deselect between accesses so array mode drops to standby
        next_fl_ce_n  = 1'b1;
        next_fl_oe_n  = 1'b1;
        next_fl_we_n  = 1'b1;
        next_fl_dq_oe = 1'b0;
      end
      st_next: begin
        if (op == `OP_READ && step == 2'h0 && !status_mode) begin
          next_state   = st_rlow;
          next_fl_addr = addr_r;
          next_fl_ce_n = 1'b0;
          next_fl_oe_n = 1'b0;
          next_cnt     = cyc8(`ACC_CYC + 3);
        end else if (op == `OP_READ && step == 2'h0) begin
          // leave status mode before array data can be read
          next_state     = st_wlow;
          next_fl_dq_out = `CMD_READ_ARRAY;
          next_fl_dq_oe  = 1'b1;
          next_fl_ce_n   = 1'b0;
          next_fl_we_n   = 1'b0;
          next_status_mode = 1'b0;
          next_cnt       = cyc8(`WP_CYC);
        end else begin
          next_state     = st_wlow;
          next_fl_addr   = addr_r;
          next_fl_dq_out = cmd;
          next_fl_dq_oe  = 1'b1;
          next_fl_ce_n   = 1'b0;
          next_fl_we_n   = 1'b0;
          next_cnt       = cyc8(`WP_CYC);
        end
      end
      st_wlow: begin
        if (cnt == 8'h00) begin
          next_fl_we_n = 1'b1;
          next_state   = st_whigh;
          next_cnt     = cyc8(`WPH_CYC);
        end
      end
      st_whigh: begin
        if (cnt == 8'h00) begin
          next_fl_dq_oe = 1'b0;
          next_fl_ce_n  = 1'b1;
          if ((op == `OP_PROG || op == `OP_ERASE) && step == 2'h0) begin
            next_step  = 2'h1; // second write follows back to back
            next_state = st_next;
          end else if (op == `OP_PROG || op == `OP_ERASE) begin
            next_status_mode = 1'b1;
            next_state = st_poll;
            next_cnt   = cyc8(`ACC_CYC + 3);
            next_fl_ce_n = 1'b0;
            next_fl_oe_n = 1'b0;
          end else if (op == `OP_READ) begin
            next_state = st_next;
            next_step  = 2'h0;
          end else begin
            if (op == `OP_CLEAR) next_status_q = 8'h80;
            if (op == `OP_ARRAY) next_status_mode = 1'b0;
            next_state = st_recov;
          end
        end
      end
      st_poll: begin
        // reads return status while the engine runs; ce stays low
        if (cnt == 8'h00) begin
          next_fl_oe_n = 1'b1;
          next_state   = st_rdone;
          next_cnt     = cyc8(`WPH_CYC);
          // flags trusted only once ready reads one
          if (dq_q[`SB_READY]) begin
            next_status_q = dq_q; // device keeps them latched
            next_state    = st_recov;
            next_fl_ce_n  = 1'b1;
          end
        end
      end
      st_rdone: begin
        if (cnt == 8'h00) begin
          next_fl_oe_n = 1'b0;
          next_state   = st_poll;
          next_cnt     = cyc8(`ACC_CYC + 3);
        end
      end
      st_rlow: begin
        if (cnt == 8'h00) begin
          next_rdata_r = dq_q;
          next_fl_ce_n = 1'b1;
          next_fl_oe_n = 1'b1;
          next_state   = st_recov;
        end
      end
      st_recov: begin
        next_busy  = 1'b0;
        next_state = st_idle;
        ev[`IRQ_DONE] = 1'b1;
        // any flag after a program or erase means the operation failed
        if ((op == `OP_PROG || op == `OP_ERASE) &&
            (next_status_q[`SB_ERASE_FAIL] || next_status_q[`SB_PROG_FAIL] ||
             next_status_q[`SB_SUPPLY])) begin
          ev[`IRQ_ERROR] = 1'b1;
        end
      end
      default: next_state = st_idle;
    endcase
    // set wins over clear
    next_irq_stat = irq_stat;
    if (reg_wr && reg_addr == `REG_IRQ_STAT) begin
      next_irq_stat = irq_stat & ~reg_wdata[2:0];
    end
    next_irq_stat = next_irq_stat | ev;
    next_irq = |(next_irq_stat & next_irq_mask);
    if (reg_rd) begin
      case (reg_addr)
        `REG_CTRL:     next_reg_rdata = {29'h0, op};
        `REG_ADDR:     next_reg_rdata = {15'h0, addr_r};
        `REG_DATA:     next_reg_rdata = {24'h0, data_r};
        `REG_STATUS:   next_reg_rdata = {18'h0, err_code, inhibit,
                                         status_mode, busy, status_q};
        `REG_IRQ_STAT: next_reg_rdata = {29'h0, irq_stat};
        `REG_IRQ_MASK: next_reg_rdata = {29'h0, irq_mask};
        `REG_RDATA:    next_reg_rdata = {24'h0, rdata_r};
        default:       next_reg_rdata = 32'h0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state       <= st_idle;
      cnt         <= 8'h00;
      op          <= 3'h0;
      step        <= 2'h0;
      busy        <= 1'b0;
      status_mode <= 1'b0;
      addr_r      <= 17'h0;
      data_r      <= 8'h00;
      rdata_r     <= 8'h00;
      status_q    <= 8'h00;
      irq_stat    <= 3'h0;
      irq_mask    <= 3'h0;
      irq         <= 1'b0;
      reg_rdata   <= 32'h0;
      fl_addr     <= 17'h0;
      fl_dq_out   <= 8'h00;
      fl_dq_oe    <= 1'b0;
      fl_ce_n     <= 1'b1;
      fl_oe_n     <= 1'b1;
      fl_we_n     <= 1'b1;
      fl_rst_n    <= 1'b0;
    end else begin
      state       <= next_state;
      cnt         <= next_cnt;
      op          <= next_op;
      step        <= next_step;
      busy        <= next_busy;
      status_mode <= next_status_mode;
      addr_r      <= next_addr_r;
      data_r      <= next_data_r;
      rdata_r     <= next_rdata_r;
      status_q    <= next_status_q;
      irq_stat    <= next_irq_stat;
      irq_mask    <= next_irq_mask;
      irq         <= next_irq;
      reg_rdata   <= next_reg_rdata;
      fl_addr     <= next_fl_addr;
      fl_dq_out   <= next_fl_dq_out;
      fl_dq_oe    <= next_fl_dq_oe;
      fl_ce_n     <= next_fl_ce_n;
      fl_oe_n     <= next_fl_oe_n;
      fl_we_n     <= next_fl_we_n;
      fl_rst_n    <= next_fl_rst_n;
    end
  end
endmodule

// ### flash_host_ctl_sva.sv
`timescale 1ns/100ps
`include "flash_ctl_defs.svh"
module flash_host_ctl_sva (
  input wire logic        clk,        // clock
  input wire logic        reset,      // async reset
  input wire logic [3:0]  reg_addr,   // register address
  input wire logic [31:0] reg_wdata,  // write data
  input wire logic        reg_wr,     // write strobe
  input wire logic        reg_rd,     // read strobe
  input wire logic [31:0] reg_rdata,  // read data
  input wire logic        irq,        // interrupt
  input wire logic [16:0] fl_addr,    // flash address
  input wire logic [7:0]  fl_dq_out,  // flash data out
  input wire logic        fl_dq_oe,   // data drive enable
  input wire logic [7:0]  fl_dq_in,   // flash data in
  input wire logic        fl_ce_n,    // chip select
  input wire logic        fl_oe_n,    // output enable
  input wire logic        fl_we_n,    // write strobe
  input wire logic        fl_rst_n    // device reset
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  sequence s_clr_req;
    reg_wr && reg_addr == `REG_CTRL && reg_wdata[2:0] == `OP_CLEAR && fl_ce_n;
  endsequence
  sequence s_clr_drive;
    !fl_we_n && !fl_ce_n && fl_dq_oe && fl_dq_out == 8'h50;
  endsequence
  property p_clear_cmd; s_clr_req |-> ##2 s_clr_drive; endproperty
  a_clear_cmd: assert property (p_clear_cmd) else $error("clear missing");
  property p_we_ce; !fl_we_n |-> !fl_ce_n && fl_oe_n; endproperty
  a_we_ce: assert property (p_we_ce) else $error("write unselected");
  property p_we_pulse; $fell(fl_we_n) |-> (!fl_we_n)[*8] ##1 fl_we_n[*4];
  endproperty
  a_we_pulse: assert property (p_we_pulse) else $error("write pulse");
  property p_hold;
    $past(fl_we_n) == 1'b0 |-> $stable(fl_dq_out) && $stable(fl_addr);
  endproperty
  a_hold: assert property (p_hold) else $error("data moved");
  property p_rd_safe; !fl_oe_n |-> fl_we_n && !fl_dq_oe && !fl_ce_n; endproperty
  a_rd_safe: assert property (p_rd_safe) else $error("read clash");
  property p_poll; $fell(fl_oe_n) |-> (!fl_oe_n)[*8] ##5 !fl_oe_n; endproperty
  a_poll: assert property (p_poll) else $error("read too short");
  property p_rdata_idle; $past(reg_rd) == 1'b0 |-> reg_rdata == 32'h0;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("rdata");
  property p_rst_rel; $fell(reset) |=> fl_rst_n; endproperty
  a_rst_rel: assert property (p_rst_rel) else $error("reset held");
  property p_rst_keep; fl_rst_n |=> fl_rst_n; endproperty
  a_rst_keep: assert property (p_rst_keep) else $error("reset pulse");
  property p_pair;
    $rose(fl_we_n) && (fl_dq_out == 8'h40 || fl_dq_out == 8'h20)
      |-> ##[1:16] $fell(fl_we_n);
  endproperty
  a_pair: assert property (p_pair) else $error("second write");
endmodule
bind flash_host_ctl flash_host_ctl_sva sva_u (.clk, .reset, .reg_addr,
  .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .irq, .fl_addr, .fl_dq_out,
  .fl_dq_oe, .fl_dq_in, .fl_ce_n, .fl_oe_n, .fl_we_n, .fl_rst_n);

// ### flash_host_ctl_tb.sv
`timescale 1ns/100ps
`include "flash_ctl_defs.svh"
module flash_host_ctl_tb;
  import flash_ctl_pkg::*;
  typedef struct packed {logic [2:0] inj; logic [2:0] op; logic [2:0] irqs;}
    row_s;
  logic        clk, reset, reg_wr, reg_rd, irq, fl_dq_oe, supply_ok;
  logic        fl_ce_n, fl_oe_n, fl_we_n, fl_rst_n;
  logic [3:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata, d;
  logic [16:0] fl_addr;
  logic [7:0]  fl_dq_out, fl_dq_in;
  logic [1:0]  inj_fail;
  int          fail_count = 0;
  int          n_tests = 0;
  // op 2 program, 3 erase; irqs refused, error, done
  row_s rows [8] = '{'{3'h0, 3'h2, 3'h1}, '{3'h1, 3'h3, 3'h3},
    '{3'h2, 3'h2, 3'h3}, '{3'h3, 3'h3, 3'h3}, '{3'h4, 3'h2, 3'h3},
    '{3'h5, 3'h3, 3'h3}, '{3'h6, 3'h2, 3'h3}, '{3'h7, 3'h3, 3'h3}};
  flash_host_ctl dut_u (.clk, .reset, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .irq, .fl_addr, .fl_dq_out, .fl_dq_oe, .fl_dq_in,
    .fl_ce_n, .fl_oe_n, .fl_we_n, .fl_rst_n);
  flash_dev_model #(.BUSY_CYC(30)) dev_u (.clk, .fl_addr, .fl_dq_out,
    .fl_dq_oe, .fl_ce_n, .fl_oe_n, .fl_we_n, .fl_rst_n, .supply_ok,
    .inj_fail, .fl_dq_in);
  //////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  // polls done bit up to 400 times; the final check catches a controller that never finishes
  task automatic wait_done;
    int n;
    n = 0;
    do begin
      rd(`REG_IRQ_STAT);
      n++;
    end while (d[0] !== 1'b1 && n < 400);
    chk(32'(d[0]), 32'h1);
  endtask
  task automatic op_done(input logic [2:0] op);
    wr(`REG_CTRL, 32'(op));
    wait_done;
  endtask
  task automatic clr;
    wr(`REG_IRQ_STAT, 32'h7);
    op_done(`OP_CLEAR);
    wr(`REG_IRQ_STAT, 32'h7);
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    #500000;
    fail_count++;
    stop_test();
  end
  initial begin
    reset = 1'b1;
    {reg_wr, reg_rd, reg_addr, reg_wdata, inj_fail} = '0;
    supply_ok = 1'b1;
    repeat (8) @(posedge clk);
    chk(32'({fl_rst_n, fl_ce_n, irq}), 32'h2);
    reset <= 1'b0;
    // device needs its reset recovery before the first command
    repeat (30) @(posedge clk);
    rd(`REG_STATUS);
    chk(d, 32'h0);
    wr(`REG_ADDR, 32'h1234);
    wr(`REG_DATA, 32'ha5);
    op_done(`OP_CLEAR);
    chk(32'({irq, d[2:0]}), 32'h1);
    wr(`REG_IRQ_MASK, 32'h7);
    repeat (2) @(posedge clk);
    chk(32'(irq), 32'h1);
    wr(`REG_IRQ_STAT, 32'h7);
    repeat (2) @(posedge clk);
    chk(32'(irq), 32'h0);
    foreach (rows[i]) begin
      supply_ok <= !rows[i].inj[0];
      inj_fail <= rows[i].inj[2:1];
      op_done(rows[i].op);
      chk(32'(d[2:0]), 32'(rows[i].irqs));
      rd(`REG_STATUS);
      chk(32'(d[13:0]), 32'({rows[i].inj, rows[i].inj[0], 4'ha,
        rows[i].inj, 3'h0}));
      clr;
      rd(`REG_STATUS);
      chk(32'(d[13:10]), 32'h0);
    end
    supply_ok <= 1'b1;
    inj_fail <= 2'b01;
    op_done(`OP_PROG);
    wr(`REG_IRQ_STAT, 32'h7);
    inj_fail <= 2'b00;
    op_done(`OP_PROG);
    chk(32'(d[2:0]), 32'h3);
    rd(`REG_STATUS);
    chk(32'(d[13:11]), 32'h2);
    clr;
    supply_ok <= 1'b0;
    op_done(`OP_ERASE);
    wr(`REG_IRQ_STAT, 32'h7);
    supply_ok <= 1'b1;
    wr(`REG_CTRL, 32'(`OP_PROG));
    rd(`REG_IRQ_STAT);
    chk(32'(d[2:0]), 32'h4);
    clr;
    op_done(`OP_PROG);
    chk(32'(d[2:0]), 32'h1);
    wr(`REG_IRQ_STAT, 32'h7);
    op_done(`OP_ARRAY);
    rd(`REG_STATUS);
    chk(32'(d[9]), 32'h0);
    wr(`REG_IRQ_STAT, 32'h7);
    wr(`REG_CTRL, 32'(`OP_PROG));
    repeat (3) @(posedge clk);
    wr(`REG_CTRL, 32'(`OP_CLEAR));
    wait_done;
    chk(32'(d[2:0]), 32'h5);
    wr(`REG_IRQ_STAT, 32'h7);
    op_done(`OP_READ);
    rd(`REG_RDATA);
    chk(32'(d[7:0]), 32'h6e);
    wr(4'hf, 32'h0);
    rd(`REG_ADDR);
    chk(d, 32'h1234);
    stop_test();
  end
endmodule
